// ===== logic/config_port_mode_and_suspend_status.v
// configuration port role select, low-power strap latch and suspend status outputs
// assumes one hub clock, asynchronous active-low reset, pins synchronised here
//
// Summary of operation
// - role select high: two-wire port serves an attached eeprom.
// - role select low: two-wire port serves an external smbus host.
// - data pin level caught at reset release is default for u1/u2.
// - strap high disables u1/u2; strap low enables them.
// - with eeprom or smbus host present, configuration bit decides instead of strap.
// - high-speed suspend output is 1 while that upstream port is suspended.
// - usb 3.0 suspend output is 1 while that upstream port is suspended.
`timescale 1ns/1ps
`include "cfg_port_defs.vh"
module config_port_mode_and_suspend_status
(
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire config_port_role_select,
	input wire config_port_clock_pin_in,
	input wire config_port_data_pin_in,
	input wire eeprom_clock_out,
	input wire eeprom_clock_oe,
	input wire eeprom_data_out,
	input wire eeprom_data_oe,
	input wire smbus_data_out,
	input wire smbus_data_oe,
	input wire external_config_present,
	input wire link_low_power_disable_bit,
	input wire hs_port_suspended,
	input wire usb3_port_suspended,
	output wire config_port_clock_pin_out,
	output wire config_port_clock_pin_oe,
	output wire config_port_data_pin_out,
	output wire config_port_data_pin_oe,
	output reg eeprom_role_active,
	output reg smbus_role_active,
	output reg port_clock_level,
	output reg port_data_level,
	output reg config_port_data_strap,
	output reg u1u2_disabled,
	output reg high_speed_upstream_suspended,
	output reg usb3_upstream_suspended
);
////////////////////////////////////////////////////////////////////////////////
// strap capture states

localparam [1:0] strap_settling = 2'h0;
localparam [1:0] strap_sampling = 2'h1;
localparam [1:0] strap_held = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// helpers

// eeprom-side or smbus-side value by the registered role
function pick_by_role;
	input eeprom_role;
	input eeprom_val;
	input smbus_val;
	begin
		pick_by_role = eeprom_role ? eeprom_val : smbus_val;
	end
endfunction

// synchronised select level to eeprom role
function role_is_eeprom;
	input role_level;
	begin
		role_is_eeprom = (role_level == `ROLE_EEPROM);
	end
endfunction

// synchronised select level to smbus host role
function role_is_smbus;
	input role_level;
	begin
		role_is_smbus = (role_level == `ROLE_SMBUS_HOST);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// input synchronisers; only the second stage is read

wire role_sync;
wire clk_pin_sync;
wire data_pin_sync;

pin_sync u_role
(
	.clk(clk),
	.arst_n(arst_n),
	.ce(ce),
	.async_in(config_port_role_select),
	.sync_out(role_sync)
);

pin_sync u_scl
(
	.clk(clk),
	.arst_n(arst_n),
	.ce(ce),
	.async_in(config_port_clock_pin_in),
	.sync_out(clk_pin_sync)
);

pin_sync u_sda
(
	.clk(clk),
	.arst_n(arst_n),
	.ce(ce),
	.async_in(config_port_data_pin_in),
	.sync_out(data_pin_sync)
);

////////////////////////////////////////////////////////////////////////////////
// pin drive by role; the smbus side never drives the clock

assign config_port_clock_pin_out = pick_by_role(eeprom_role_active, eeprom_clock_out, 1'h0);
assign config_port_clock_pin_oe = pick_by_role(eeprom_role_active, eeprom_clock_oe, 1'h0);
assign config_port_data_pin_out = pick_by_role(eeprom_role_active, eeprom_data_out, smbus_data_out);
assign config_port_data_pin_oe = pick_by_role(eeprom_role_active, eeprom_data_oe, smbus_data_oe);

////////////////////////////////////////////////////////////////////////////////
// registered role

always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		eeprom_role_active <= 1'h0;
		smbus_role_active <= 1'h0;
	end
	else if (ce)
	begin
		eeprom_role_active <= role_is_eeprom(role_sync);
		smbus_role_active <= role_is_smbus(role_sync);
	end
end

////////////////////////////////////////////////////////////////////////////////
// registered pin levels

always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		port_clock_level <= 1'h0;
		port_data_level <= 1'h0;
	end
	else if (ce)
	begin
		port_clock_level <= clk_pin_sync;
		port_data_level <= data_pin_sync;
	end
end

////////////////////////////////////////////////////////////////////////////////
// strap capture
// the data pin must stay put for a few cycles around reset release:
// the sync flops start at zero, so the strap waits until they are flushed

reg [1:0] strap_state;
reg [1:0] next_strap_state;
reg [1:0] settle_count;
reg [1:0] next_settle_count;
reg next_strap;
wire strap_valid;

assign strap_valid = (strap_state == strap_held);

always @*
begin
	next_strap_state = strap_state;
	next_settle_count = settle_count;
	next_strap = config_port_data_strap;
	case (strap_state)
	strap_settling:
	begin
		next_settle_count = settle_count + 2'h1;
		if (settle_count == `STRAP_SETTLE_EDGES - 2'h1)
			next_strap_state = strap_sampling;
	end
	strap_sampling:
	begin
		next_strap = data_pin_sync;
		next_strap_state = strap_held;
	end
	strap_held:
	begin
		next_strap_state = strap_held;
	end
	default:
	begin
		next_strap_state = strap_held;
	end
	endcase
end

always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		strap_state <= strap_settling;
		settle_count <= `STRAP_COUNT_RESET;
		config_port_data_strap <= `STRAP_RESET_VALUE;
	end
	else if (ce)
	begin
		strap_state <= next_strap_state;
		settle_count <= next_settle_count;
		config_port_data_strap <= next_strap;
	end
end

////////////////////////////////////////////////////////////////////////////////
// u1/u2 decision; without external config present, low-power states stay enabled until the strap is known

reg next_u1u2_disabled;

always @*
begin
	next_u1u2_disabled = `STRAP_RESET_VALUE;
	if (external_config_present)
		next_u1u2_disabled = link_low_power_disable_bit;
	else if (strap_valid)
		next_u1u2_disabled = config_port_data_strap;
end

always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
		u1u2_disabled <= 1'h0;
	else if (ce)
		u1u2_disabled <= next_u1u2_disabled;
end

////////////////////////////////////////////////////////////////////////////////
// suspend status outputs

always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		high_speed_upstream_suspended <= 1'h0;
		usb3_upstream_suspended <= 1'h0;
	end
	else if (ce)
	begin
		high_speed_upstream_suspended <= hs_port_suspended;
		usb3_upstream_suspended <= usb3_port_suspended;
	end
end

endmodule

// ===== common/cfg_port_defs.vh
// constants for the configuration port mode and suspend status block
// assumes inclusion by bare name from the design files
`ifndef CFG_PORT_DEFS_VH
`define CFG_PORT_DEFS_VH
`define ROLE_SMBUS_HOST 1'h0
`define ROLE_EEPROM 1'h1
`define STRAP_RESET_VALUE 1'h0
`define SYNC_STAGES 2
`define STRAP_SETTLE_EDGES 2'h2
`define STRAP_COUNT_RESET 2'h0
`endif

// ===== logic/pin_sync.v
// two-flop synchroniser for one asynchronous level
// assumes clk is the hub clock and arst_n an asynchronous active-low reset
`timescale 1ns/1ps
module pin_sync
(
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire async_in,
	output reg sync_out
);
reg stage1;
always @(posedge clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		stage1 <= 1'h0;
		sync_out <= 1'h0;
	end
	else if (ce)
	begin
		stage1 <= async_in;
		sync_out <= stage1;
	end
end
endmodule

// ===== verification/cfg_far_model.sv
// far side model: eeprom or host holding the data line at a level
`timescale 1ns/1ps
module cfg_far_model(input wire clk, input wire lvl, output reg sda);
	always @(posedge clk) sda <= lvl;
endmodule

// ===== verification/cfg_port_asserts.sv
// checker for role, strap and suspend outputs; bound onto the top module
`timescale 1ns/1ps
module cfg_port_asserts
(
	input wire clk,
	input wire arst_n,
	input wire ce,
	input wire external_config_present,
	input wire link_low_power_disable_bit,
	input wire hs_port_suspended,
	input wire usb3_port_suspended,
	input wire config_port_role_select,
	input wire config_port_data_strap,
	input wire u1u2_disabled,
	input wire high_speed_upstream_suspended,
	input wire usb3_upstream_suspended,
	input wire eeprom_role_active,
	input wire smbus_role_active,
	input wire config_port_clock_pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// enabled edges since reset, and enabled edges with a steady role select
	reg [2:0] since_reset;
	reg [2:0] role_run;
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			since_reset <= 3'h0;
		else if (ce && since_reset != 3'h7)
			since_reset <= since_reset + 3'h1;
	end
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			role_run <= 3'h0;
		else if (!ce || $changed(config_port_role_select))
			role_run <= 3'h0;
		else if (role_run != 3'h7)
			role_run <= role_run + 3'h1;
	end
	AST_HS: assert property (ce |=> high_speed_upstream_suspended == $past(hs_port_suspended)) else $error("hs");
	AST_U3: assert property (ce |=> usb3_upstream_suspended == $past(usb3_port_suspended)) else $error("u3");
	AST_CFG: assert property (ce && external_config_present |=> u1u2_disabled == $past(link_low_power_disable_bit))
		else $error("cfg");
	AST_STRAP: assert property (ce && !external_config_present && since_reset >= 3'h4
		|=> u1u2_disabled == $past(config_port_data_strap)) else $error("strap");
	AST_HOLD: assert property (since_reset == 3'h7 |=> $stable(config_port_data_strap)) else $error("hold");
	AST_EE: assert property (role_run == 3'h7 |-> eeprom_role_active == $past(config_port_role_select))
		else $error("ee");
	AST_SM: assert property (role_run == 3'h7 |-> smbus_role_active != $past(config_port_role_select))
		else $error("sm");
	AST_EXCL: assert property (!(eeprom_role_active && smbus_role_active)) else $error("excl");
	AST_CLK_OE: assert property (!eeprom_role_active |-> !config_port_clock_pin_oe) else $error("clock oe");
	cover property (eeprom_role_active);
	cover property (smbus_role_active);
	cover property (high_speed_upstream_suspended && u1u2_disabled);
	cover property (config_port_data_strap);
endmodule
bind config_port_mode_and_suspend_status cfg_port_asserts chk_i (.*);

// ===== verification/config_port_mode_and_suspend_status_tb_top.sv
// random bench: suspend, config, role and pin traffic with clock-enable pauses and two resets
// assumes the far model holds the data line at the bench's level, also through reset
`timescale 1ns/1ps
module config_port_mode_and_suspend_status_tb_top;
	logic clk = 0, arst_n = 0, ce = 1, config_port_role_select = 1;
	logic [11:0] v = 12'h000;
	logic [11:0] ev = 12'h000;
	logic er = 1'h1;
	logic es = 1'h0;
	int bad_count = 0, total_checks = 0, i;
	wire sda, config_port_clock_pin_out, config_port_clock_pin_oe, config_port_data_pin_out, config_port_data_pin_oe;
	wire eeprom_role_active, smbus_role_active, port_clock_level, port_data_level, config_port_data_strap;
	wire u1u2_disabled, high_speed_upstream_suspended, usb3_upstream_suspended;
	config_port_mode_and_suspend_status dut (.*, .config_port_data_pin_in(sda), .hs_port_suspended(v[0]),
		.usb3_port_suspended(v[1]), .external_config_present(v[2]), .link_low_power_disable_bit(v[3]),
		.config_port_clock_pin_in(v[4]), .eeprom_clock_out(v[5]), .eeprom_clock_oe(v[6]), .eeprom_data_out(v[7]),
		.eeprom_data_oe(v[8]), .smbus_data_out(v[9]), .smbus_data_oe(v[10]));
	cfg_far_model far (.clk(clk), .lvl(v[11]), .sda(sda));
	task chk(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin bad_count++; $display("MISMATCH %0t output", $time); end
	endtask
	task chk_pin(input logic [3:0] g, input logic [3:0] e);
		total_checks++;
		if (g !== e) begin bad_count++; $display("MISMATCH %0t pin drive", $time); end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	function logic exp_u(input logic [11:0] x, input logic s);
		return x[2] ? x[3] : s;
	endfunction
	function logic [3:0] exp_pin(input logic role, input logic [11:0] x);
		return role ? {x[5], x[6], x[7], x[8]} : {1'h0, 1'h0, x[9], x[10]};
	endfunction
	// five edges per step: the data pin needs four edges (far model plus three enabled) and the clock pin three to reach the level outputs
	task run_phase(input int n);
		for (i = 0; i < n; i++)
		begin
			@(posedge clk);
			v <= 12'($urandom);
			ce <= (i % 7 != 3);
			if (i % 9 == 0) config_port_role_select <= 1'($urandom);
			repeat (4) @(posedge clk);
			@(negedge clk);
			if (ce) begin ev = v; er = config_port_role_select; end
			chk(high_speed_upstream_suspended, ev[0]);
			chk(usb3_upstream_suspended, ev[1]);
			chk(u1u2_disabled, exp_u(ev, es));
			chk(config_port_data_strap, es);
			chk(eeprom_role_active, er);
			chk(smbus_role_active, !er);
			chk(port_clock_level, ev[4]);
			chk(port_data_level, ev[11]);
			chk_pin({config_port_clock_pin_out, config_port_clock_pin_oe, config_port_data_pin_out,
				config_port_data_pin_oe}, exp_pin(er, v));
		end
	endtask
	initial forever #4 clk = ~clk;
	initial begin #60000 bad_count++; wrap_up; end
	initial
	begin
		void'($urandom(18));
		repeat (12) @(posedge clk);
		arst_n <= 1;
		run_phase(300);
		// second reset with the data line held high: the strap must come up high
		@(posedge clk);
		ce <= 1'h1;
		v <= 12'h800;
		repeat (4) @(posedge clk);
		arst_n <= 0;
		repeat (12) @(posedge clk);
		arst_n <= 1;
		es = 1'h1;
		run_phase(300);
		wrap_up;
	end
endmodule
